// ==== hdl/timer_window_map.vh ====
// Register map, field positions, reset values and counts of the window-gate timer control
`ifndef TIMER_WINDOW_MAP_VH
`define TIMER_WINDOW_MAP_VH
`define OFF_CMP_LOW      8'h00
`define OFF_CMP_MID      8'h04
`define OFF_CMP_HIGH     8'h08
`define OFF_GATE         8'h0c
`define OFF_CTRL_ONE     8'h14
`define OFF_CTRL_TWO     8'h18
`define OFF_STATUS       8'h1c
`define CTRL_ONE_RESET   8'h88
`define CTRL_TWO_RESET   8'h00
`define GATE_RESET       8'h00
`define CMP_RESET        18'h3ffff
`define F_CLR            7
`define F_RUN_HI         6
`define F_RUN_LO         5
`define F_CK_HI          4
`define F_CK_LO          2
`define F_MODE_HI        1
`define F_MODE_LO        0
`define F_GCK_HI         3
`define F_GCK_LO         2
`define RUN_STOP         2'h0
`define MODE_RESERVED    2'h1
`define MODE_PWM         2'h2
`define CK_EXT           3'h7
`define GATE_FULL        5'h10
`endif

// ==== hdl/gate_pulse_gen.v ====
// Window gate pulse generator: high and low periods counted in gate clock ticks
`timescale 1ns/100ps
`include "timer_window_map.vh"
module gate_pulse_gen #(
	parameter W = 5
) (
	input  wire       clk_sys,
	input  wire       rst_n,
	input  wire       clkEn,
	input  wire       run,
	input  wire       tick,
	input  wire [3:0] highSetting,
	input  wire [3:0] lowSetting,
	output reg        gateLevel
);
	// ************************************************
	// Period counter
	// ************************************************
	reg  [W-1:0] left_q;
	wire [W-1:0] highLen = `GATE_FULL - {1'b0, highSetting};
	wire [W-1:0] lowLen  = `GATE_FULL - {1'b0, lowSetting};
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			left_q    <= {W{1'b0}};
			gateLevel <= 1'b0;
		end else if (clkEn) begin
			if (!run) begin
				left_q    <= highLen;
				gateLevel <= 1'b1;
			end else if (tick) begin
				if (left_q <= 5'h01) begin
					gateLevel <= ~gateLevel;
					left_q    <= gateLevel ? lowLen : highLen;
				end else begin
					left_q <= left_q - 5'h01;
				end
			end
		end
	end
endmodule

// ==== hdl/timer_window_gate_control.v ====
// Register block and count control of the 18-bit window-gated timer
// How it works
// - 18-bit compare limit plus 8-bit gate setting
// - low byte write blocks compare until high
// - compare limit reads return live counter
// - high byte bits 7..2 read zero
// - clock source decode incl. divider-tap select
// - mode 01 reserved, 10 pulse width
// - gate high lasts 16 minus high setting
// - gate low lasts 16 minus low setting
`timescale 1ns/100ps
`include "timer_window_map.vh"
module timer_window_gate_control #(
	parameter CW = 18
) (
	input  wire          clk_sys,
	input  wire          rst_n,
	input  wire          clkEn,
	input  wire          psel,
	input  wire          penable,
	input  wire          pwrite,
	input  wire [7:0]    paddr,
	input  wire [31:0]   pwdata,
	output wire          pready,
	output wire          pslverr,
	output reg  [31:0]   prdata,
	input  wire          mainOscTick,
	input  wire          subOscTick,
	input  wire [23:0]   mainDiv,
	input  wire [15:0]   subDiv,
	input  wire          slowMode,
	input  wire          divider_tap_sel,
	input  wire          external_count_input,
	output reg           compareMatch,
	output wire          gatePulse,
	output wire          counting
);
	// ************************************************
	// Registers
	// ************************************************
	reg  [CW-1:0] compare_limit_reg_q;
	reg  [7:0]    window_gate_reg_q;
	reg  [7:0]    timer_control_one_q;
	reg  [7:0]    ctrlTwo_q;
	reg           cmpBlocked_q;
	reg  [CW-1:0] count_q;
	reg           overflow_q;
	reg  [2:0]    extSync_q;
	reg           extLevel_q;
	reg  [31:0]   rdMux;
	reg  [23:0]   mainDivLast_q;
	reg  [15:0]   subDivLast_q;
	wire          wrEn = psel & penable & pwrite;
	wire          rdAcc = psel & ~pwrite;
	// Setup cycle of a read: the read data register loads here
	wire          rdSetup = psel & ~penable & ~pwrite;
	wire [1:0]    run_control = timer_control_one_q[`F_RUN_HI:`F_RUN_LO];
	wire [2:0]    clock_source_sel = timer_control_one_q[`F_CK_HI:`F_CK_LO];
	wire [1:0]    operating_mode_sel = timer_control_one_q[`F_MODE_HI:`F_MODE_LO];
	wire [1:0]    gate_clock_sel = ctrlTwo_q[`F_GCK_HI:`F_GCK_LO];
	wire          running = (run_control == 2'h2);
	wire          useSub = divider_tap_sel | slowMode;
	wire          mapped;
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~mapped;
	assign mapped  = (paddr == `OFF_CMP_LOW) | (paddr == `OFF_CMP_MID) |
		(paddr == `OFF_CMP_HIGH) | (paddr == `OFF_GATE) | (paddr == `OFF_CTRL_ONE) |
		(paddr == `OFF_CTRL_TWO) | (paddr == `OFF_STATUS);
	// ************************************************
	// Divider taps and edge detection
	// ************************************************
	wire [23:0] mainRise = mainDiv & ~mainDivLast_q;
	wire [15:0] subRise  = subDiv & ~subDivLast_q;
	reg         srcTick;
	reg         gateTick;
	// Falling edge of the filtered pin level, one cycle long
	wire        extFall = extLevel_q & ~extSync_q[1] & ~extSync_q[2];
	always @* begin
		case (clock_source_sel)
		3'h0:    srcTick = mainOscTick;
		3'h1:    srcTick = subOscTick;
		3'h2:    srcTick = useSub ? subRise[14] : mainRise[22];
		3'h3:    srcTick = useSub ? subRise[4]  : mainRise[12];
		3'h4:    srcTick = useSub ? subRise[2]  : mainRise[10];
		3'h5:    srcTick = mainRise[6];
		3'h6:    srcTick = mainRise[2];
		default: srcTick = extFall;
		endcase
		case (gate_clock_sel)
		2'h0:    gateTick = useSub ? subRise[3] : mainRise[11];
		2'h1:    gateTick = useSub ? subRise[4] : mainRise[12];
		2'h2:    gateTick = useSub ? subRise[5] : mainRise[13];
		default: gateTick = 1'b0;
		endcase
	end
	// ************************************************
	// Gate pulse
	// ************************************************
	gate_pulse_gen #(.W(5)) uGate (
		.clk_sys     (clk_sys),
		.rst_n       (rst_n),
		.clkEn       (clkEn),
		.run         (running),
		.tick        (gateTick),
		.highSetting (window_gate_reg_q[7:4]),
		.lowSetting  (window_gate_reg_q[3:0]),
		.gateLevel   (gatePulse)
	);
	// Reserved mode never counts, so a bad mode code leaves the counter parked
	wire modeOk = (operating_mode_sel != `MODE_RESERVED);
	wire advance = running & modeOk & srcTick &
		((operating_mode_sel == `MODE_PWM) ? gatePulse : 1'b1);
	wire hit = (count_q == compare_limit_reg_q) & ~cmpBlocked_q;
	assign counting = running & gatePulse;
	// ************************************************
	// State update
	// ************************************************
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			compare_limit_reg_q <= `CMP_RESET;
			window_gate_reg_q   <= `GATE_RESET;
			timer_control_one_q <= `CTRL_ONE_RESET;
			ctrlTwo_q           <= `CTRL_TWO_RESET;
			cmpBlocked_q        <= 1'b0;
			count_q             <= {CW{1'b0}};
			overflow_q          <= 1'b0;
			compareMatch        <= 1'b0;
			mainDivLast_q       <= 24'h000000;
			subDivLast_q        <= 16'h0000;
		end else if (clkEn) begin
			mainDivLast_q <= mainDiv;
			subDivLast_q  <= subDiv;
			compareMatch  <= 1'b0;
			if (!running) begin
				// Clear also drops the overflow flag
				if (timer_control_one_q[`F_CLR]) begin
					count_q    <= {CW{1'b0}};
					overflow_q <= 1'b0;
				end
			end else if (advance) begin
				if (hit) begin
					count_q      <= {CW{1'b0}};
					compareMatch <= 1'b1;
				end else begin
					count_q <= count_q + 18'h00001;
					if (&count_q)
						overflow_q <= 1'b1;
				end
			end
			if (wrEn) begin
				case (paddr)
				`OFF_CMP_LOW: begin
					compare_limit_reg_q[7:0] <= pwdata[7:0];
					cmpBlocked_q <= 1'b1;
				end
				`OFF_CMP_MID: begin
					compare_limit_reg_q[15:8] <= pwdata[7:0];
					cmpBlocked_q <= 1'b1;
				end
				`OFF_CMP_HIGH: begin
					compare_limit_reg_q[17:16] <= pwdata[1:0];
					cmpBlocked_q <= 1'b0;
				end
				`OFF_GATE:     window_gate_reg_q   <= pwdata[7:0];
				`OFF_CTRL_ONE: timer_control_one_q <= pwdata[7:0];
				`OFF_CTRL_TWO: ctrlTwo_q           <= {pwdata[7:1], 1'b0};
				default: ;
				endcase
			end
		end
	end
	// ************************************************
	// Read mux
	// ************************************************
	always @* begin
		rdMux = 32'h00000000;
		if (rdAcc) begin
			case (paddr)
			`OFF_CMP_LOW:  rdMux[7:0] = count_q[7:0];
			`OFF_CMP_MID:  rdMux[7:0] = count_q[15:8];
			`OFF_CMP_HIGH: rdMux[1:0] = count_q[17:16];
			`OFF_GATE:     rdMux[7:0] = window_gate_reg_q;
			`OFF_CTRL_ONE: rdMux[7:0] = timer_control_one_q;
			`OFF_CTRL_TWO: rdMux[7:0] = ctrlTwo_q;
			`OFF_STATUS:   rdMux[7:6] = {counting, overflow_q};
			default:       rdMux = 32'h00000000;
			endcase
		end
	end
	// Snapshot taken in the setup cycle, so a running count cannot tear mid-access
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			prdata <= 32'h00000000;
		end else if (clkEn && rdSetup) begin
			prdata <= rdMux;
		end
	end
	// ************************************************
	// Count pin synchroniser
	// ************************************************
	// Level moves only once stages two and three agree, so a glitch never counts
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			extSync_q  <= 3'h7;
			extLevel_q <= 1'b1;
		end else if (clkEn) begin
			extSync_q <= {extSync_q[1:0], external_count_input};
			if (extSync_q[1] == extSync_q[2])
				extLevel_q <= extSync_q[2];
		end
	end
endmodule

// ==== tb/timer_window_chk.sv ====
// Assertion checker on the ports of the window-gated timer
`timescale 1ns/100ps
module timer_window_chk (
	input wire        clk_sys,
	input wire        rst_n,
	input wire        clkEn,
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [7:0]  paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire        pready,
	input wire        compareMatch,
	input wire        gatePulse,
	input wire        counting
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	wire rdOn = psel && penable && !pwrite;
	wire wrOn = psel && penable && pwrite && clkEn;
	logic blocked_q;
	logic runOn_q;
	// Shadow of the run field, so the gate check does not lean on the design's decode
	always @(posedge clk_sys) begin
		if (!rst_n)
			runOn_q <= 1'h0;
		else if (wrOn && paddr == 8'h14)
			runOn_q <= (pwdata[6:5] == 2'h2);
	end
	// Set by a low or mid write, freed by the high write
	always @(posedge clk_sys) begin
		if (!rst_n)
			blocked_q <= 1'h0;
		else if (wrOn && paddr == 8'h08)
			blocked_q <= 1'h0;
		else if (wrOn && (paddr == 8'h00 || paddr == 8'h04))
			blocked_q <= 1'h1;
	end
	match_blocked_a: assert property (blocked_q |=> !compareMatch)
		else $error("compare match while blocked");
	high_zero_a: assert property (rdOn && paddr == 8'h08 |-> prdata[31:2] == 30'h0)
		else $error("high byte upper bits set");
	cmp_width_a: assert property (rdOn && paddr == 8'h00 |-> prdata[31:8] == 24'h0)
		else $error("counter low read too wide");
	gate_width_a: assert property (rdOn && paddr == 8'h0c |-> prdata[31:8] == 24'h0)
		else $error("gate register read too wide");
	ctrl_width_a: assert property (rdOn && paddr == 8'h14 |-> prdata[31:8] == 24'h0)
		else $error("control read too wide");
	count_gate_a: assert property (counting |-> gatePulse && runOn_q)
		else $error("counting outside gate high");
	freeze_gate_a: assert property (!clkEn |=> $stable(gatePulse))
		else $error("gate moved while frozen");
	ready_high_a: assert property (psel && penable |-> pready)
		else $error("wait state inserted");
endmodule
bind timer_window_gate_control timer_window_chk timer_window_chk_inst (.clk_sys, .rst_n,
	.clkEn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .compareMatch, .gatePulse,
	.counting);

// ==== tb/tb_timer_window_gate_control.sv ====
// Self-checking bench for the window-gated timer register block
`timescale 1ns/100ps
`include "timer_window_map.vh"
module tb_timer_window_gate_control;
	logic        clk_sys, rst_n, clkEn, psel, penable, pwrite, pready, pslverr, errQ;
	logic        compareMatch, gatePulse, counting, extPin;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rdQ;
	logic [23:0] mainDiv = 24'h000000;
	int          fail_count, samples_checked, n;
	// Sub clock and slow mode are left idle: only main taps and the count pin are exercised
	timer_window_gate_control timer_window_gate_control_inst (.clk_sys, .rst_n, .clkEn, .psel,
		.penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .prdata,
		.mainOscTick(mainDiv[0]), .subOscTick(1'h0), .mainDiv, .subDiv(16'h0),
		.slowMode(1'h0), .divider_tap_sel(1'h0), .external_count_input(extPin),
		.compareMatch, .gatePulse, .counting);
	initial begin
		clk_sys = 1'h0;
		forever #20 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) mainDiv <= mainDiv + 24'h1;
	// ****************
	// Bus and check tasks
	// ****************
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'h1;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'h1 && n < 50);
		if (pready !== 1'h1) begin
			fail_count++;
			$display("Error %0t: no ready on the bus", $time);
		end
		rdQ = prdata;
		errQ = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("Error %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// Selector 0 watches the compare pulse, any other the gate level
	function automatic logic probe(input int which);
		return (which == 0) ? compareMatch : gatePulse;
	endfunction
	task automatic waitFor(input int which, input logic v, input int lim);
		n = 0;
		while (probe(which) !== v && n < lim) begin
			@(posedge clk_sys);
			n++;
		end
	endtask
	task automatic results;
		$display("Counts: %0d checked, %0d mismatches", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		// The gate periods dominate: about 25000 cycles, so this leaves ample margin
		repeat (60000) @(posedge clk_sys);
		fail_count++;
		results;
	end
	initial begin
		{rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
		extPin = 1'h1;
		clkEn = 1'h1;
		fail_count = 0;
		samples_checked = 0;
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'h1;
		apb(0, `OFF_CTRL_ONE, 0);
		chk(rdQ, 32'h88);
		apb(1, `OFF_GATE, 32'h1ef);
		apb(0, `OFF_GATE, 0);
		chk(rdQ, 32'hef);
		apb(1, `OFF_CMP_HIGH, 32'hff);
		apb(0, `OFF_CMP_HIGH, 0);
		chk(rdQ, 32'h0);
		apb(1, `OFF_CMP_LOW, 32'h55);
		apb(0, `OFF_CMP_LOW, 0);
		chk(rdQ, 32'h0);
		apb(0, 8'h10, 0);
		chk({rdQ[30:0], errQ}, 32'h1);
		clkEn <= 1'h0;
		apb(1, `OFF_GATE, 32'h12);
		clkEn <= 1'h1;
		apb(0, `OFF_GATE, 0);
		chk(rdQ, 32'hef);
		$display("Register tests done");
		// Limit 3 at main/2^7, high byte not yet written, so no match may come
		apb(1, `OFF_CMP_LOW, 32'h3);
		apb(1, `OFF_CMP_MID, 32'h0);
		apb(1, `OFF_CTRL_ONE, 32'h94);
		apb(1, `OFF_CTRL_ONE, 32'hd4);
		waitFor(0, 1'h1, 1500);
		chk(n, 1500);
		apb(1, `OFF_CTRL_ONE, 32'h94);
		apb(1, `OFF_CMP_HIGH, 32'h0);
		apb(1, `OFF_CTRL_ONE, 32'hd4);
		waitFor(0, 1'h1, 1500);
		chk(compareMatch, 1'h1);
		$display("Compare tests done");
		// Reserved mode at main/2^7: several source ticks pass, the count must not move
		apb(1, `OFF_CTRL_ONE, 32'h95);
		apb(1, `OFF_CTRL_ONE, 32'h55);
		repeat (3) @(posedge clk_sys);
		chk(counting, 1'h1);
		repeat (600) @(posedge clk_sys);
		apb(1, `OFF_CTRL_ONE, 32'h15);
		apb(0, `OFF_CMP_LOW, 0);
		chk(rdQ, 32'h0);
		$display("Reserved mode tests done");
		apb(1, `OFF_CTRL_ONE, 32'h8a);
		apb(1, `OFF_CTRL_TWO, 32'h0);
		apb(1, `OFF_CTRL_ONE, 32'hca);
		waitFor(1, 1'h0, 20000);
		waitFor(1, 1'h1, 10000);
		chk(n, 4096);
		chk(counting, 1'h1);
		waitFor(1, 1'h0, 10000);
		chk(n, 8192);
		$display("Gate tests done");
		// Event counter from the pin: two falling edges, then read while stopped
		apb(1, `OFF_CTRL_ONE, 32'h0a);
		apb(1, `OFF_CTRL_ONE, 32'h9f);
		apb(1, `OFF_CTRL_ONE, 32'h5f);
		repeat (2) begin
			extPin <= 1'h0;
			repeat (6) @(posedge clk_sys);
			extPin <= 1'h1;
			repeat (6) @(posedge clk_sys);
		end
		apb(1, `OFF_CTRL_ONE, 32'h1f);
		apb(0, `OFF_CMP_LOW, 0);
		chk(rdQ, 32'h2);
		$display("Event tests done");
		results;
	end
endmodule
